// ### core/ssd_status_display.sv
// Function
// - Normal: green display shows state, LED off
// - Fault: steady red LED, error digit
// - Warning: flashing LED, state/warning alternate
// - Point flashes when processor runs with supply ok and no hardware fault, else dark
// - Bottom segment lit when healthy and enabled
// - Speed zero, clockwise, anticlockwise segments
// - Ballast on blanks direction segment
// - Command and input change 0.1 s pulses
// - Current limit segment flashing or steady
// - Faults are hex digits, D reserved; the code still latches and shows code D like any other fault
// - Fault opens ready contact
// - Fault drops ready message to zero
// - Fault clears ready state indication
// - Disable keeps latched fault displayed
// - Enable plus cancel clears fault
// - Powerup with enable: red LED, no digit
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_status_display
   import ssd_pkg::*;
#(
   parameter logic [`SSD_CNT_W-1:0] PULSE_CYC = `SSD_CNT_W'(`SSD_PULSE_CYC),
   parameter logic [`SSD_CNT_W-1:0] BLINK_CYC = `SSD_CNT_W'(`SSD_BLINK_CYC),
   parameter logic [`SSD_CNT_W-1:0] ALT_CYC   = `SSD_CNT_W'(`SSD_ALT_CYC)
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        drive_release_input,
   input  wire logic        cancel_errors_input,
   input  wire logic        fault_req,
   input  wire ssd_code_t   fault_code_in,
   input  wire logic        warn_active,
   input  wire ssd_code_t   warn_code,
   input  wire logic        cpu_active,
   input  wire logic        aux_ok,
   input  wire logic        hw_fail,
   input  wire logic        speed_zero_flag,
   input  wire logic        speed_negative,
   input  wire logic        ballast_on,
   input  wire logic        cur_cont_limit,
   input  wire logic        cur_max_limit,
   input  wire logic        cmd_received,
   input  wire logic        input_changed,
   output logic      [6:0]  seg,
   output logic             seg_dp,
   output logic             seg_green,
   output logic             fault_led,
   output logic             ready_relay_contact,
   output logic             ready_msg,
   output logic             ready_state,
   output logic             irq
);
   logic            blink;
   logic            alt;
   logic            cmd_pulse;
   logic            chg_pulse;
   logic            fault_active;
   ssd_code_t       fault_code;
   logic            startup_fault;
   logic            startup_done;
   logic            cancel_q;
   logic            sw_cancel;
   logic            clear_req;
   logic            warn_q;
   logic [`SSD_IRQ_W-1:0] irq_stat;
   logic [`SSD_IRQ_W-1:0] irq_en;
   logic [`SSD_IRQ_W-1:0] irq_evt;
   ssd_mode_e       mode;
   ssd_seg_t        state_pat;
   ssd_seg_t        next_seg;
   logic            next_led;
   logic            wr;
   logic            rd_ok;

   function automatic ssd_seg_t hex_font(input ssd_code_t d);
      unique case (d)
         4'h0: hex_font = 7'h3F;
         4'h1: hex_font = 7'h06;
         4'h2: hex_font = 7'h5B;
         4'h3: hex_font = 7'h4F;
         4'h4: hex_font = 7'h66;
         4'h5: hex_font = 7'h6D;
         4'h6: hex_font = 7'h7D;
         4'h7: hex_font = 7'h07;
         4'h8: hex_font = 7'h7F;
         4'h9: hex_font = 7'h6F;
         4'hA: hex_font = 7'h77;
         4'hB: hex_font = 7'h7C;
         4'hC: hex_font = 7'h39;
         4'hD: hex_font = 7'h5E;
         4'hE: hex_font = 7'h79;
         4'hF: hex_font = 7'h71;
      endcase
   endfunction : hex_font

   ssd_flasher #(.HALF(BLINK_CYC)) u_blink (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .phase    (blink)
   );

   ssd_flasher #(.HALF(ALT_CYC)) u_alt (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .phase    (alt)
   );

   ssd_pulse_stretch #(.LEN(PULSE_CYC)) u_cmd_pulse (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .trig     (cmd_received),
      .active   (cmd_pulse)
   );

   ssd_pulse_stretch #(.LEN(PULSE_CYC)) u_chg_pulse (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .trig     (input_changed),
      .active   (chg_pulse)
   );

   // APB slave, zero wait states
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign rd_ok   = (paddr == `SSD_OFS_STATUS) || (paddr == `SSD_OFS_CTRL) ||
                    (paddr == `SSD_OFS_IRQ_STAT) || (paddr == `SSD_OFS_IRQ_EN) ||
                    (paddr == `SSD_OFS_IRQ_CLR);
   assign pslverr = psel && penable && !rd_ok;

   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         `SSD_OFS_STATUS: begin
            prdata[`SSD_ST_FAULT]   = fault_active;
            prdata[`SSD_ST_STARTUP] = startup_fault;
            prdata[`SSD_ST_WARN]    = warn_active;
            prdata[`SSD_ST_READY]   = ready_msg;
            prdata[`SSD_ST_CODE_HI:`SSD_ST_CODE_LO] = fault_code;
         end
         `SSD_OFS_IRQ_STAT: prdata[`SSD_IRQ_W-1:0] = irq_stat;
         `SSD_OFS_IRQ_EN:   prdata[`SSD_IRQ_W-1:0] = irq_en;
         default:           prdata = 32'h0000_0000;
      endcase
   end

   // Cancel over the bus is a one-cycle strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_cancel <= 1'b0;
      end else begin
         sw_cancel <= wr && (paddr == `SSD_OFS_CTRL) && pwdata[`SSD_CTRL_CANCEL];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cancel_q <= 1'b0;
         warn_q   <= 1'b0;
      end else begin
         cancel_q <= cancel_errors_input;
         warn_q   <= warn_active;
      end
   end

   // Clearing needs the enable present
   assign clear_req = drive_release_input &&
                      ((cancel_errors_input && !cancel_q) || sw_cancel);

   // Fault latch; a new report wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_active <= 1'b0;
         fault_code   <= 4'h0;
      end else if (fault_req && !fault_active) begin
         fault_active <= 1'b1;
         fault_code   <= fault_code_in;
      end else if (clear_req && !fault_req) begin
         fault_active <= 1'b0;
      end
   end

   // Enable sampled at the first edge after reset release
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         startup_done  <= 1'b0;
         startup_fault <= 1'b0;
      end else if (!startup_done) begin
         startup_done  <= 1'b1;
         startup_fault <= drive_release_input;
      end else if (clear_req) begin
         startup_fault <= 1'b0;
      end
   end

   always_comb begin
      if (fault_active) begin
         mode = SSD_FAULT;
      end else if (warn_active) begin
         mode = SSD_WARNING;
      end else begin
         mode = SSD_NORMAL;
      end
   end

   // Drive state pattern
   always_comb begin
      state_pat = 7'h00;
      state_pat[`SSD_SEG_D] = !hw_fail && drive_release_input;
      state_pat[`SSD_SEG_G] = speed_zero_flag;
      state_pat[`SSD_SEG_C] = !speed_zero_flag && !speed_negative && !ballast_on;
      state_pat[`SSD_SEG_E] = !speed_zero_flag && speed_negative && !ballast_on;
      state_pat[`SSD_SEG_A] = cur_max_limit || (cur_cont_limit && blink);
      state_pat[`SSD_SEG_F] = cmd_pulse;
      state_pat[`SSD_SEG_B] = chg_pulse;
   end

   always_comb begin
      next_seg = state_pat;
      next_led = startup_fault;
      unique case (mode)
         SSD_NORMAL: begin
            next_seg = state_pat;
         end
         SSD_WARNING: begin
            next_seg = alt ? hex_font(warn_code) : state_pat;
            next_led = blink || startup_fault;
         end
         SSD_FAULT: begin
            next_seg = hex_font(fault_code);
            next_led = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         seg       <= 7'h00;
         seg_dp    <= 1'b0;
         seg_green <= 1'b0;
         fault_led <= 1'b0;
      end else begin
         seg       <= next_seg;
         seg_dp    <= aux_ok && !hw_fail && cpu_active && blink;
         seg_green <= 1'b1;
         fault_led <= next_led;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ready_relay_contact <= 1'b0;
         ready_msg           <= 1'b0;
         ready_state         <= 1'b0;
      end else begin
         ready_relay_contact <= startup_done && !fault_active && !startup_fault;
         ready_msg           <= startup_done && !fault_active && !startup_fault;
         ready_state         <= startup_done && !fault_active && !startup_fault &&
                                aux_ok && !hw_fail;
      end
   end

   // Sticky events; set wins over clear
   always_comb begin
      irq_evt = '0;
      irq_evt[`SSD_IRQ_FAULT]   = fault_req && !fault_active;
      irq_evt[`SSD_IRQ_WARN]    = warn_active && !warn_q;
      irq_evt[`SSD_IRQ_CLEARED] = fault_active && clear_req && !fault_req;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat <= '0;
      end else if (wr && paddr == `SSD_OFS_IRQ_CLR) begin
         irq_stat <= (irq_stat & ~pwdata[`SSD_IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat <= irq_stat | irq_evt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en <= '0;
      end else if (wr && paddr == `SSD_OFS_IRQ_EN) begin
         irq_en <= pwdata[`SSD_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat & irq_en);

   property p_normal_led;
      @(posedge core_clk) disable iff (!rst_b)
      (mode == SSD_NORMAL && !startup_fault) |=> (!fault_led && seg_green);
   endproperty
   a_normal_led: assert property (p_normal_led) else $error("normal led wrong");

   property p_fault_digit;
      @(posedge core_clk) disable iff (!rst_b)
      fault_active |=> (fault_led && seg == hex_font($past(fault_code)));
   endproperty
   a_fault_digit: assert property (p_fault_digit) else $error("fault digit wrong");

   property p_warn_flash;
      @(posedge core_clk) disable iff (!rst_b)
      (mode == SSD_WARNING && !startup_fault) |=> (fault_led == $past(blink));
   endproperty
   a_warn_flash: assert property (p_warn_flash) else $error("warning flash wrong");

   property p_dp_dark;
      @(posedge core_clk) disable iff (!rst_b)
      (!aux_ok || hw_fail) |=> !seg_dp;
   endproperty
   a_dp_dark: assert property (p_dp_dark) else $error("point lit without supply");

   property p_ballast_blank;
      @(posedge core_clk) disable iff (!rst_b)
      (ballast_on && mode == SSD_NORMAL) |=> (!seg[`SSD_SEG_C] && !seg[`SSD_SEG_E]);
   endproperty
   a_ballast_blank: assert property (p_ballast_blank) else $error("direction lit");

   property p_relay_open;
      @(posedge core_clk) disable iff (!rst_b)
      $rose(fault_active) |=> (!ready_relay_contact && !ready_msg && !ready_state);
   endproperty
   a_relay_open: assert property (p_relay_open) else $error("ready kept on fault");

   property p_fault_held;
      @(posedge core_clk) disable iff (!rst_b)
      (fault_active && !drive_release_input) |=> fault_active;
   endproperty
   a_fault_held: assert property (p_fault_held) else $error("fault lost without enable");

   property p_cancel;
      @(posedge core_clk) disable iff (!rst_b)
      (fault_active && clear_req && !fault_req) |=> !fault_active ##1 !fault_led[*1];
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel did not clear");

   property p_startup;
      @(posedge core_clk) disable iff (!rst_b)
      (startup_fault && !fault_active) |=>
         (fault_led && ($past(mode) == SSD_WARNING || seg == $past(state_pat)));
   endproperty
   a_startup: assert property (p_startup) else $error("startup indication wrong");

   property p_priority;
      @(posedge core_clk) disable iff (!rst_b)
      (fault_active && warn_active) |=> (fault_led && seg == hex_font($past(fault_code)));
   endproperty
   a_priority: assert property (p_priority) else $error("warning beat fault");
endmodule : ssd_status_display
`default_nettype wire

// ### shared/ssd_regs.svh
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// Register byte offsets
`define SSD_OFS_STATUS    12'h000
`define SSD_OFS_CTRL      12'h004
`define SSD_OFS_IRQ_STAT  12'h008
`define SSD_OFS_IRQ_EN    12'h00C
`define SSD_OFS_IRQ_CLR   12'h010

// Status fields
`define SSD_ST_FAULT      0
`define SSD_ST_STARTUP    1
`define SSD_ST_WARN       2
`define SSD_ST_READY      3
`define SSD_ST_CODE_LO    4
`define SSD_ST_CODE_HI    7

// Control fields
`define SSD_CTRL_CANCEL   0

// Interrupt event bits
`define SSD_IRQ_FAULT     0
`define SSD_IRQ_WARN      1
`define SSD_IRQ_CLEARED   2
`define SSD_IRQ_W         3

// Segment positions: a top, b upper right, c lower right, d bottom,
// e lower left, f upper left, g middle
`define SSD_SEG_A         0
`define SSD_SEG_B         1
`define SSD_SEG_C         2
`define SSD_SEG_D         3
`define SSD_SEG_E         4
`define SSD_SEG_F         5
`define SSD_SEG_G         6

// Timing
`define SSD_CLK_HZ        125000000
`define SSD_PULSE_MS      100
`define SSD_BLINK_MS      250
`define SSD_ALT_MS        1000
`define SSD_CNT_W         28
`define SSD_MS_CYC(ms)    ((`SSD_CLK_HZ / 1000) * (ms))
`define SSD_PULSE_CYC     `SSD_MS_CYC(`SSD_PULSE_MS)
`define SSD_BLINK_CYC     `SSD_MS_CYC(`SSD_BLINK_MS)
`define SSD_ALT_CYC       `SSD_MS_CYC(`SSD_ALT_MS)

`endif

// ### shared/ssd_pkg.sv
package ssd_pkg;
   typedef enum logic [1:0] {SSD_NORMAL, SSD_WARNING, SSD_FAULT} ssd_mode_e;
   typedef logic [3:0] ssd_code_t;
   typedef logic [6:0] ssd_seg_t;
endpackage : ssd_pkg

// ### core/ssd_flasher.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_flasher
   import ssd_pkg::*;
#(
   parameter logic [`SSD_CNT_W-1:0] HALF = `SSD_CNT_W'(`SSD_BLINK_CYC)
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   output var  logic phase
);
   logic [`SSD_CNT_W-1:0] cnt;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt   <= '0;
         phase <= 1'b0;
      end else if (cnt == HALF - `SSD_CNT_W'(1)) begin
         cnt   <= '0;
         phase <= ~phase;
      end else begin
         cnt <= cnt + `SSD_CNT_W'(1);
      end
   end

   property p_phase_holds;
      @(posedge core_clk) disable iff (!rst_b)
      (cnt != HALF - `SSD_CNT_W'(1)) |=> $stable(phase);
   endproperty
   a_phase_holds: assert property (p_phase_holds) else $error("flash phase moved early");
endmodule : ssd_flasher
`default_nettype wire

// ### core/ssd_pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_pulse_stretch
   import ssd_pkg::*;
#(
   parameter logic [`SSD_CNT_W-1:0] LEN = `SSD_CNT_W'(`SSD_PULSE_CYC)
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic trig,
   output var  logic active
);
   logic [`SSD_CNT_W-1:0] cnt;

   // Retrigger restarts the full length
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt    <= '0;
         active <= 1'b0;
      end else if (trig) begin
         cnt    <= LEN - `SSD_CNT_W'(1);
         active <= 1'b1;
      end else if (cnt != '0) begin
         cnt <= cnt - `SSD_CNT_W'(1);
      end else begin
         active <= 1'b0;
      end
   end

   property p_pulse_start;
      @(posedge core_clk) disable iff (!rst_b)
      trig |=> active;
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("segment pulse missing");

   property p_pulse_end;
      @(posedge core_clk) disable iff (!rst_b)
      (active && cnt == '0 && !trig) |=> !active;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("segment pulse too long");
endmodule : ssd_pulse_stretch
`default_nettype wire

// ### sim/ssd_panel.sv
`timescale 1ns/1ps
`default_nettype none
// Front panel lamps: counts how often the red lamp and the point change
module ssd_panel (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic fault_led,
   input  wire logic seg_dp,
   output var  int   led_edges,
   output var  int   dp_edges
);
   logic led_q;
   logic dp_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         led_q     <= 1'b0;
         dp_q      <= 1'b0;
         led_edges <= 0;
         dp_edges  <= 0;
      end else begin
         led_q <= fault_led;
         dp_q  <= seg_dp;
         if (led_q != fault_led) led_edges <= led_edges + 1;
         if (dp_q != seg_dp) dp_edges <= dp_edges + 1;
      end
   end
endmodule : ssd_panel
`default_nettype wire

// ### sim/servo_status_fault_display_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssd_regs.svh"
module servo_status_fault_display_bench;
   import ssd_pkg::*;
   localparam int PC = 20, BC = 8, AC = 32;
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, seg_dp, seg_green, fault_led, relay, ready_msg, ready_state, irq;
   logic en = 1'b1, cancel = 1'b0, freq = 1'b0, warn = 1'b0, cpu = 1'b0, aux = 1'b1;
   logic hwf = 1'b0, zero = 1'b1, neg = 1'b0, ball = 1'b0, ccl = 1'b0, mcl = 1'b0;
   logic cmd = 1'b0, chg = 1'b0;
   ssd_code_t fcode = 4'h0, wcode = 4'h0;
   ssd_seg_t  seg;
   int        miscompares = 0, compares = 0, led_edges, dp_edges, e0, hits;
   ssd_seg_t  font [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                           7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

   always #4 core_clk = ~core_clk;

   ssd_status_display #(.PULSE_CYC(28'(PC)), .BLINK_CYC(28'(BC)), .ALT_CYC(28'(AC))) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_release_input(en), .cancel_errors_input(cancel), .fault_req(freq),
      .fault_code_in(fcode), .warn_active(warn), .warn_code(wcode), .cpu_active(cpu),
      .aux_ok(aux), .hw_fail(hwf), .speed_zero_flag(zero), .speed_negative(neg),
      .ballast_on(ball), .cur_cont_limit(ccl), .cur_max_limit(mcl), .cmd_received(cmd),
      .input_changed(chg), .seg(seg), .seg_dp(seg_dp), .seg_green(seg_green),
      .fault_led(fault_led), .ready_relay_contact(relay), .ready_msg(ready_msg),
      .ready_state(ready_state), .irq(irq));

   ssd_panel i_panel (.core_clk(core_clk), .rst_b(rst_b), .fault_led(fault_led),
      .seg_dp(seg_dp), .led_edges(led_edges), .dp_edges(dp_edges));

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Answer taken just before the access edge, where it has settled
      @(negedge core_clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(negedge core_clk);
      end
      if (n == 50) check("pready", 32'h0, 32'h1);
      rd      = prdata;
      err     = pslverr;
      @(posedge core_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle cycle keeps the next request off this time step
      @(posedge core_clk);
   endtask : apb

   task automatic ready_set(input logic exp);
      check("relay", 32'(relay), 32'(exp));
      check("ready_msg", 32'(ready_msg), 32'(exp));
      check("ready_state", 32'(ready_state), 32'(exp));
   endtask : ready_set

   task automatic t_startup();
      check("startup led", 32'(fault_led), 32'h1);
      check("startup seg", 32'(seg), 32'h48);
      ready_set(1'b0);
      cancel <= 1'b1;
      tick(3);
      cancel <= 1'b0;
      tick(3);
      check("cleared led", 32'(fault_led), 32'h0);
      ready_set(1'b1);
   endtask : t_startup

   task automatic t_normal();
      logic [6:0] exp [5] = '{7'h48, 7'h0C, 7'h18, 7'h08, 7'h10};
      for (int i = 0; i < 5; i++) begin
         zero <= (i == 0);
         neg  <= (i == 2 || i == 4);
         ball <= (i == 3);
         en   <= (i != 4);
         tick(4);
         check("state seg", 32'(seg), 32'(exp[i]));
         check("green", 32'(seg_green), 32'h1);
         check("led off", 32'(fault_led), 32'h0);
      end
      en   <= 1'b1;
      zero <= 1'b1;
      neg  <= 1'b0;
   endtask : t_normal

   task automatic t_faults();
      apb(1'b1, `SSD_OFS_IRQ_EN, 32'h1);
      for (int c = 0; c < 16; c++) begin
         fcode <= 4'(c);
         freq  <= 1'b1;
         tick(1);
         freq  <= 1'b0;
         tick(3);
         check("fault digit", 32'(seg), 32'(font[c]));
         check("fault led", 32'(fault_led), 32'h1);
         check("irq", 32'(irq), 32'h1);
         ready_set(1'b0);
         apb(1'b0, `SSD_OFS_STATUS, 32'h0);
         check("status", rd & 32'hF1, 32'(c * 16 + 1));
         en <= 1'b0;
         tick(4);
         check("kept digit", 32'(seg), 32'(font[c]));
         check("kept led", 32'(fault_led), 32'h1);
         apb(1'b1, `SSD_OFS_CTRL, 32'h1);
         tick(3);
         check("no clear off", 32'(fault_led), 32'h1);
         en <= 1'b1;
         tick(1);
         apb(1'b1, `SSD_OFS_CTRL, 32'h1);
         apb(1'b1, `SSD_OFS_IRQ_CLR, 32'h7);
         tick(3);
         check("clear led", 32'(fault_led), 32'h0);
         check("irq clr", 32'(irq), 32'h0);
         ready_set(1'b1);
      end
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      check("unmapped data", rd, 32'h0);
   endtask : t_faults

   task automatic t_warning();
      int sd;
      int ss;
      sd    = 0;
      ss    = 0;
      wcode <= 4'h5;
      warn  <= 1'b1;
      e0 = led_edges;
      for (int i = 0; i < 4 * AC; i++) begin
         tick(1);
         if (seg === font[5]) sd++;
         if (seg === 7'h48) ss++;
      end
      check("warn flash", 32'(led_edges - e0 >= 4), 32'h1);
      check("warn alt", 32'(sd > AC && ss > AC), 32'h1);
      apb(1'b0, `SSD_OFS_IRQ_STAT, 32'h0);
      check("irq warn", rd, 32'h2);
      fcode <= 4'h3;
      freq  <= 1'b1;
      tick(1);
      freq  <= 1'b0;
      tick(3);
      e0 = led_edges;
      tick(3 * AC);
      check("prio led", 32'(led_edges - e0), 32'h0);
      check("prio digit", 32'(seg), 32'(font[3]));
      warn <= 1'b0;
      apb(1'b1, `SSD_OFS_CTRL, 32'h1);
      tick(4);
   endtask : t_warning

   task automatic t_segments();
      cpu <= 1'b1;
      e0 = dp_edges;
      tick(4 * BC);
      check("dp flash", 32'(dp_edges - e0 >= 3), 32'h1);
      hwf <= 1'b1;
      tick(3);
      e0 = dp_edges;
      tick(3 * BC);
      check("dp dark hw", 32'(dp_edges - e0 + 32'(seg_dp)), 32'h0);
      check("bottom off", 32'(seg[3]), 32'h0);
      hwf <= 1'b0;
      aux <= 1'b0;
      tick(3);
      e0 = dp_edges;
      tick(3 * BC);
      check("dp dark aux", 32'(dp_edges - e0 + 32'(seg_dp)), 32'h0);
      aux <= 1'b1;
      mcl <= 1'b1;
      hits = 0;
      tick(3);
      for (int i = 0; i < 3 * BC; i++) begin
         tick(1);
         hits += seg[0];
      end
      check("max steady", 32'(hits), 32'(3 * BC));
      mcl <= 1'b0;
      ccl <= 1'b1;
      hits = 0;
      tick(3);
      for (int i = 0; i < 4 * BC; i++) begin
         tick(1);
         hits += seg[0];
      end
      check("cont flash", 32'(hits > 0 && hits < 4 * BC), 32'h1);
      ccl <= 1'b0;
      tick(3);
      check("limit dark", 32'(seg[0]), 32'h0);
      cmd <= 1'b1;
      tick(1);
      cmd <= 1'b0;
      chg <= 1'b1;
      tick(1);
      chg <= 1'b0;
      tick(3);
      check("cmd pulse", 32'(seg[5]), 32'h1);
      check("chg pulse", 32'(seg[1]), 32'h1);
      tick(PC - 6);
      check("cmd held", 32'(seg[5]), 32'h1);
      check("chg held", 32'(seg[1]), 32'h1);
      tick(6);
      check("pulse end", 32'({seg[5], seg[1]}), 32'h0);
   endtask : t_segments

   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   initial begin
      #(8 * 30000);
      miscompares++;
      results();
   end

   initial begin
      tick(16);
      rst_b <= 1'b1;
      tick(4);
      t_startup();
      t_normal();
      t_faults();
      t_warning();
      t_segments();
      results();
   end
endmodule : servo_status_fault_display_bench
`default_nettype wire
